// File: common/dmcs_pkg.sv
// constants, command codes and state type of the ddr2/mddr command sequencer
// Function
// - a precharge-all always precedes every auto-refresh command
// - after the precharge-all, refreshes repeat at the programmed refresh interval
// - all open-page state is dropped around refresh, so the next access activates
// - periodic refresh has no disable and runs whenever operating normally
// - precharge-all follows reset/init and precedes every refresh and mode write
// - address bit 10 is high during precharge-all
// - single-bank precharge closes only the bank on the bank-select outputs
// - a closed row is activated first, bank on bank-select, row on address
// - read or write waits the row-to-column delay after activation
// - read drives column strobe low, row strobe and write enable high
// - every read fetches a burst of eight beats
// - cas latency is 2 to 5, additive latency forced to zero
// - unneeded read beats are dropped; a pending read may cut the burst
// - rows stay open; precharge only when page state is no longer valid
// - write data follows after cas latency minus one, or one for mobile ddr
// - writes are bursts of eight with per-byte masks for partial writes
// - beats beyond a short write request are masked out
// - mode writes select the register by bank-select, value on address bits
// - mode writes happen only during initialization
// - data path is 16 bits, little-endian, halfword addressed
// - memory data sits right-aligned on the low data lanes
// - the sequencer runs on the memory clock, half the double-rate clock
package dmcs_pkg;
  // ==========================================================
  // clock and timing
  localparam int CLK_MHZ = 100;
  localparam int T_INIT_US = 200;
  localparam int INIT_CYC = T_INIT_US * CLK_MHZ;
  localparam int T_MRD_NS = 20;
  localparam logic [14:0] MRD_CYC = 15'((T_MRD_NS * CLK_MHZ + 999) / 1000);
  // ==========================================================
  // command codes as {ras_n, cas_n, we_n}
  localparam logic [2:0] CMD_NOP = 3'h7;
  localparam logic [2:0] CMD_ACT = 3'h3;
  localparam logic [2:0] CMD_PRE = 3'h2;
  localparam logic [2:0] CMD_MRS = 3'h0;
  localparam logic [2:0] CMD_REF = 3'h1;
  localparam logic [2:0] CMD_RD = 3'h5;
  localparam logic [2:0] CMD_WR = 3'h4;
  // ==========================================================
  // address fields and mode words
  localparam int AP_BIT = 10;
  localparam int MR_BL_LSB = 0;
  localparam int MR_CL_LSB = 4;
  localparam int EMR_AL_LSB = 3;
  localparam logic [2:0] MR_BL8 = 3'h3;
  localparam logic [2:0] BA_MR = 3'h0;
  localparam logic [2:0] BA_EMR = 3'h1;
  localparam logic [2:0] CL_MIN = 3'h2;
  localparam logic [2:0] CL_MAX = 3'h5;
  localparam logic [3:0] BURST = 4'h8;
  // ==========================================================
  // sequencer states
  typedef enum logic [3:0] {
    ST_INIT = 4'h0,
    ST_PALL = 4'h1,
    ST_MRS = 4'h2,
    ST_EMRS = 4'h3,
    ST_REF = 4'h4,
    ST_IDLE = 4'h5,
    ST_PRE = 4'h6,
    ST_ACT = 4'h7,
    ST_CMD = 4'h8
  } dmcs_state_e;
endpackage

// File: core/dmcs_count.sv
// loadable down-counter used for command spacing and refresh interval
`timescale 1ns/1ps
module dmcs_count #(
  parameter int W = 8
) (
  input wire logic clk, // memory clock
  input wire logic rst, // async reset, active high
  input wire logic ld, // load val this cycle
  input wire logic [W-1:0] val, // cycles until zero
  output logic zero // count has run out
);
  typedef struct packed {
    logic [W-1:0] cnt;
  } dmcs_cnt_s;
  dmcs_cnt_s q;
  dmcs_cnt_s next_q;

  always_comb begin
    next_q = q;
    if (ld) begin
      next_q.cnt = val;
    end else if (q.cnt != '0) begin
      next_q.cnt = q.cnt - W'(1);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign zero = (q.cnt == '0);
endmodule

// File: core/dmcs_core.sv
// command sequencer: init, refresh, page management, read/write bursts
`timescale 1ns/1ps
module dmcs_core #(
  parameter int INIT_WAIT_CYC = dmcs_pkg::INIT_CYC // power-up wait, cycles
) (
  input wire logic CLK_SYS, // memory clock
  input wire logic RST, // async reset, active high
  input wire logic [12:0] CFG_REFRESH_INTERVAL, // refresh_interval_field
  input wire logic [2:0] CFG_CAS_LAT, // cas latency 2..5
  input wire logic CFG_MDDR, // 1: mobile ddr write latency
  input wire logic [3:0] CFG_TRCD, // activate to column, cycles
  input wire logic [3:0] CFG_TRP, // precharge period, cycles
  input wire logic [7:0] CFG_TRFC, // refresh period, cycles
  input wire logic [13:0] CFG_EMR, // extended mode word
  input wire logic REQ_VALID, // request present
  output logic REQ_READY, // request taken when high with valid
  input wire logic REQ_WRITE, // 1 write, 0 read
  input wire logic [2:0] REQ_BANK, // bank
  input wire logic [13:0] REQ_ROW, // row
  input wire logic [10:0] REQ_COL, // column
  input wire logic [3:0] REQ_LEN, // beats needed 1..8
  input wire logic [127:0] REQ_WDATA, // write beats, beat 0 lowest
  input wire logic [15:0] REQ_WBE, // byte enables, two per beat
  output logic [15:0] RD_DATA, // read beat
  output logic RD_VALID, // read beat strobe
  output logic INIT_DONE, // init sequence finished
  output logic DDR_CKE, // clock enable
  output logic DDR_CS_N, // chip select
  output logic DDR_RAS_N, // row strobe
  output logic DDR_CAS_N, // column strobe
  output logic DDR_WE_N, // write enable
  output logic [2:0] DDR_BA, // bank select
  output logic [13:0] DDR_A, // address
  output logic [1:0] DDR_DQM, // write byte masks
  output logic [15:0] DDR_DQ_O, // data out
  output logic DDR_DQ_OE, // data drive enable
  input wire logic [15:0] DDR_DQ_I // data in
);
  // ==========================================================
  // state
  typedef struct packed {
    dmcs_pkg::dmcs_state_e st;
    dmcs_pkg::dmcs_state_e ret;
    logic started;
    logic init_done;
    logic ref_pend;
    logic ready;
    logic [7:0] pg_open;
    logic [7:0][13:0] pg_row;
    logic rq_wr;
    logic [2:0] rq_bank;
    logic [13:0] rq_row;
    logic [10:0] rq_col;
    logic [3:0] rq_len;
    logic [127:0] wdata;
    logic [15:0] wbe;
    logic e_act;
    logic e_wr;
    logic [2:0] e_dly;
    logic [2:0] e_beat;
    logic [3:0] e_len;
    logic cke;
    logic cs_n;
    logic [2:0] cmd;
    logic [2:0] ba;
    logic [13:0] a;
    logic [15:0] dq;
    logic dq_oe;
    logic [1:0] dqm;
    logic [15:0] rd_data;
    logic rd_valid;
  } dmcs_core_s;

  dmcs_core_s q;
  dmcs_core_s next_q;
  logic w_ld;
  logic [14:0] w_val;
  logic w_zero;
  logic r_ld;
  logic [12:0] r_val;
  logic r_zero;
  logic [2:0] cl;
  logic [2:0] wl;
  logic [2:0] wb;
  logic [3:0] len_eff;
  logic take;

  function automatic logic [14:0] span(input logic [14:0] t);
    span = (t == 15'h0) ? 15'h0 : t - 15'h1;
  endfunction

  // ==========================================================
  // timers
  dmcs_count #(.W(15)) u_wait (
    .clk(CLK_SYS),
    .rst(RST),
    .ld(w_ld),
    .val(w_val),
    .zero(w_zero)
  );

  // interval counter reloads on each expiry; held loaded until init is done
  assign r_ld = !q.init_done || r_zero;
  assign r_val = (CFG_REFRESH_INTERVAL == 13'h0) ? 13'h0 : CFG_REFRESH_INTERVAL - 13'h1;

  dmcs_count #(.W(13)) u_refresh (
    .clk(CLK_SYS),
    .rst(RST),
    .ld(r_ld),
    .val(r_val),
    .zero(r_zero)
  );

  // ==========================================================
  // latencies
  always_comb begin
    if (CFG_CAS_LAT < dmcs_pkg::CL_MIN) begin
      cl = dmcs_pkg::CL_MIN;
    end else if (CFG_CAS_LAT > dmcs_pkg::CL_MAX) begin
      cl = dmcs_pkg::CL_MAX;
    end else begin
      cl = CFG_CAS_LAT;
    end
    wl = CFG_MDDR ? 3'h1 : cl - 3'h1;
    len_eff = (REQ_LEN == 4'h0 || REQ_LEN > dmcs_pkg::BURST) ? dmcs_pkg::BURST : REQ_LEN;
  end

  // ==========================================================
  // next state
  always_comb begin
    next_q = q;
    w_ld = 1'b0;
    w_val = 15'h0;
    wb = 3'h0;
    take = REQ_VALID && q.ready;
    next_q.cmd = dmcs_pkg::CMD_NOP;
    next_q.rd_valid = 1'b0;

    // data engine: one beat per memory clock, the phy doubles it onto the pins
    if (q.e_act) begin
      if (q.e_dly != 3'h0) begin
        next_q.e_dly = q.e_dly - 3'h1;
      end
      if (q.e_wr && q.e_dly == 3'h1) begin
        wb = 3'h0;
        next_q.dq_oe = 1'b1;
      end else if (q.e_dly == 3'h0 && q.e_beat == 3'h7) begin
        next_q.e_act = 1'b0;
        next_q.dq_oe = 1'b0;
      end else if (q.e_dly == 3'h0) begin
        wb = q.e_beat + 3'h1;
      end
      if (q.e_dly == 3'h0) begin
        next_q.e_beat = wb;
      end
      if (q.e_wr && next_q.dq_oe) begin
        next_q.dq = q.wdata[16*wb +: 16];
        if ({1'b0, wb} >= q.e_len) begin
          next_q.dqm = 2'h3;
        end else begin
          next_q.dqm = ~q.wbe[2*wb +: 2];
        end
      end else begin
        next_q.dqm = 2'h0;
      end
      if (!q.e_wr && q.e_dly == 3'h0) begin
        next_q.rd_data = DDR_DQ_I;
        next_q.rd_valid = {1'b0, q.e_beat} < q.e_len;
      end
    end

    case (q.st)
      dmcs_pkg::ST_INIT: begin
        if (!q.started) begin
          next_q.started = 1'b1;
          w_ld = 1'b1;
          w_val = span(15'(INIT_WAIT_CYC));
        end else if (w_zero) begin
          next_q.cke = 1'b1;
          next_q.cs_n = 1'b0;
          w_ld = 1'b1;
          w_val = span(dmcs_pkg::MRD_CYC);
          next_q.st = dmcs_pkg::ST_PALL;
          next_q.ret = dmcs_pkg::ST_MRS;
        end
      end
      dmcs_pkg::ST_PALL: begin
        if (w_zero && !q.e_act) begin
          next_q.cmd = dmcs_pkg::CMD_PRE;
          next_q.a = 14'h0;
          next_q.a[dmcs_pkg::AP_BIT] = 1'b1;
          next_q.pg_open = 8'h0;
          w_ld = 1'b1;
          w_val = span({11'h0, CFG_TRP});
          next_q.st = q.ret;
        end
      end
      dmcs_pkg::ST_MRS: begin
        if (w_zero) begin
          next_q.cmd = dmcs_pkg::CMD_MRS;
          next_q.ba = dmcs_pkg::BA_MR;
          next_q.a = 14'h0;
          next_q.a[dmcs_pkg::MR_BL_LSB +: 3] = dmcs_pkg::MR_BL8;
          next_q.a[dmcs_pkg::MR_CL_LSB +: 3] = cl;
          w_ld = 1'b1;
          w_val = span(dmcs_pkg::MRD_CYC);
          next_q.st = dmcs_pkg::ST_PALL;
          next_q.ret = dmcs_pkg::ST_EMRS;
        end
      end
      dmcs_pkg::ST_EMRS: begin
        if (w_zero) begin
          next_q.cmd = dmcs_pkg::CMD_MRS;
          next_q.ba = dmcs_pkg::BA_EMR;
          next_q.a = CFG_EMR;
          next_q.a[dmcs_pkg::EMR_AL_LSB +: 3] = 3'h0;
          w_ld = 1'b1;
          w_val = span(dmcs_pkg::MRD_CYC);
          next_q.st = dmcs_pkg::ST_PALL;
          next_q.ret = dmcs_pkg::ST_REF;
        end
      end
      dmcs_pkg::ST_REF: begin
        if (w_zero) begin
          next_q.cmd = dmcs_pkg::CMD_REF;
          next_q.pg_open = 8'h0;
          next_q.ref_pend = 1'b0;
          next_q.init_done = 1'b1;
          w_ld = 1'b1;
          w_val = span({7'h0, CFG_TRFC});
          next_q.st = dmcs_pkg::ST_IDLE;
        end
      end
      dmcs_pkg::ST_IDLE: begin
        if (q.ref_pend) begin
          next_q.st = dmcs_pkg::ST_PALL;
          next_q.ret = dmcs_pkg::ST_REF;
        end else if (take) begin
          next_q.rq_wr = REQ_WRITE;
          next_q.rq_bank = REQ_BANK;
          next_q.rq_row = REQ_ROW;
          next_q.rq_col = REQ_COL;
          next_q.rq_len = len_eff;
          if (REQ_WRITE) begin
            next_q.wdata = REQ_WDATA;
            next_q.wbe = REQ_WBE;
          end
          // an open page is kept until a different row needs its bank or the precharge-all before a refresh
          if (!q.pg_open[REQ_BANK]) begin
            next_q.st = dmcs_pkg::ST_ACT;
          end else if (q.pg_row[REQ_BANK] != REQ_ROW) begin
            next_q.st = dmcs_pkg::ST_PRE;
          end else begin
            next_q.st = dmcs_pkg::ST_CMD;
          end
        end
      end
      dmcs_pkg::ST_PRE: begin
        if (w_zero && !q.e_act) begin
          next_q.cmd = dmcs_pkg::CMD_PRE;
          next_q.ba = q.rq_bank;
          next_q.a = 14'h0;
          next_q.pg_open[q.rq_bank] = 1'b0;
          w_ld = 1'b1;
          w_val = span({11'h0, CFG_TRP});
          next_q.st = dmcs_pkg::ST_ACT;
        end
      end
      dmcs_pkg::ST_ACT: begin
        if (w_zero) begin
          next_q.cmd = dmcs_pkg::CMD_ACT;
          next_q.ba = q.rq_bank;
          next_q.a = q.rq_row;
          next_q.pg_open[q.rq_bank] = 1'b1;
          next_q.pg_row[q.rq_bank] = q.rq_row;
          w_ld = 1'b1;
          w_val = span({11'h0, CFG_TRCD});
          next_q.st = dmcs_pkg::ST_CMD;
        end
      end
      dmcs_pkg::ST_CMD: begin
        // a read may cut a read burst once its needed beats are in
        if (w_zero && (!q.e_act || (!q.rq_wr && !q.e_wr && q.e_dly == 3'h0
            && {1'b0, q.e_beat} >= q.e_len - 4'h1))) begin
          next_q.cmd = q.rq_wr ? dmcs_pkg::CMD_WR : dmcs_pkg::CMD_RD;
          next_q.ba = q.rq_bank;
          next_q.a = {2'h0, q.rq_col[10], 1'b0, q.rq_col[9:0]};
          next_q.e_act = 1'b1;
          next_q.e_wr = q.rq_wr;
          next_q.e_dly = q.rq_wr ? wl : cl;
          next_q.e_beat = 3'h0;
          next_q.e_len = q.rq_len;
          next_q.st = dmcs_pkg::ST_IDLE;
        end
      end
      default: begin
        next_q.st = dmcs_pkg::ST_IDLE;
      end
    endcase

    // an expiry in the same cycle as the refresh wins over the clear
    if (q.init_done && r_zero) begin
      next_q.ref_pend = 1'b1;
    end
    next_q.ready = (next_q.st == dmcs_pkg::ST_IDLE) && !next_q.ref_pend;
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      q <= '0;
      q.cmd <= dmcs_pkg::CMD_NOP;
      q.cs_n <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

  // ==========================================================
  // outputs
  assign REQ_READY = q.ready;
  assign RD_DATA = q.rd_data;
  assign RD_VALID = q.rd_valid;
  assign INIT_DONE = q.init_done;
  assign DDR_CKE = q.cke;
  assign DDR_CS_N = q.cs_n;
  assign DDR_RAS_N = q.cmd[2];
  assign DDR_CAS_N = q.cmd[1];
  assign DDR_WE_N = q.cmd[0];
  assign DDR_BA = q.ba;
  assign DDR_A = q.a;
  assign DDR_DQM = q.dqm;
  assign DDR_DQ_O = q.dq;
  assign DDR_DQ_OE = q.dq_oe;

  // ==========================================================
  // checks
  logic [2:0] cmd_now;
  logic [2:0] last_cmd;
  logic last_a10;
  logic [4:0] since_act;
  logic act_seen;
  assign cmd_now = {DDR_RAS_N, DDR_CAS_N, DDR_WE_N};

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      last_cmd <= 3'h7;
      last_a10 <= 1'b0;
      since_act <= 5'h0;
      act_seen <= 1'b0;
    end else begin
      if (cmd_now != dmcs_pkg::CMD_NOP) begin
        last_cmd <= cmd_now;
        last_a10 <= DDR_A[10];
      end
      if (cmd_now == dmcs_pkg::CMD_ACT) begin
        since_act <= 5'h1;
        act_seen <= 1'b1;
      end else begin
        if (since_act != 5'h1f) begin
          since_act <= since_act + 5'h1;
        end
        if (cmd_now == dmcs_pkg::CMD_REF) begin
          act_seen <= 1'b0;
        end
      end
    end
  end

  ref_after_pall_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    cmd_now == dmcs_pkg::CMD_REF |-> last_cmd == dmcs_pkg::CMD_PRE && last_a10)
    else $error("refresh without preceding precharge-all");
  mode_after_pall_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    cmd_now == dmcs_pkg::CMD_MRS |-> last_cmd == dmcs_pkg::CMD_PRE && last_a10)
    else $error("mode write without preceding precharge-all");
  pall_addr_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    $past(q.st == dmcs_pkg::ST_PALL) && cmd_now == dmcs_pkg::CMD_PRE |-> DDR_A[10])
    else $error("precharge-all without a10 high");
  pre_bank_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    $past(q.st == dmcs_pkg::ST_PRE) && cmd_now == dmcs_pkg::CMD_PRE
    |-> !DDR_A[10] && DDR_BA == $past(q.rq_bank))
    else $error("bank precharge on wrong bank");
  rcd_gap_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    cmd_now == dmcs_pkg::CMD_RD || cmd_now == dmcs_pkg::CMD_WR
    |-> since_act >= {1'b0, CFG_TRCD})
    else $error("column command too soon after activate");
  page_miss_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    cmd_now == dmcs_pkg::CMD_RD || cmd_now == dmcs_pkg::CMD_WR |-> act_seen)
    else $error("access after refresh without activate");
  mode_init_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    cmd_now == dmcs_pkg::CMD_MRS |-> !INIT_DONE)
    else $error("mode write after init");
  mddr_wl_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    cmd_now == dmcs_pkg::CMD_WR && CFG_MDDR |=> DDR_DQ_OE)
    else $error("mobile ddr write data not one cycle later");
  wr_burst_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    $rose(DDR_DQ_OE) |-> DDR_DQ_OE [*8] ##1 !DDR_DQ_OE)
    else $error("write burst not eight beats");
  mask_tail_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    DDR_DQ_OE && {1'b0, q.e_beat} >= q.e_len |-> DDR_DQM == 2'h3)
    else $error("surplus write beat not masked");
  ref_served_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    $rose(q.ref_pend) |-> ##[1:600] cmd_now == dmcs_pkg::CMD_REF)
    else $error("refresh request not served");

  ref_seen_c: cover property (@(posedge CLK_SYS) disable iff (RST)
    INIT_DONE && cmd_now == dmcs_pkg::CMD_REF);
  rd_cut_c: cover property (@(posedge CLK_SYS) disable iff (RST)
    cmd_now == dmcs_pkg::CMD_RD && $past(q.e_act) && !$past(q.e_wr));
  bank_pre_c: cover property (@(posedge CLK_SYS) disable iff (RST)
    cmd_now == dmcs_pkg::CMD_PRE && !DDR_A[10]);
  short_wr_c: cover property (@(posedge CLK_SYS) disable iff (RST)
    DDR_DQ_OE && DDR_DQM == 2'h3);
endmodule

// File: test/dmcs_sdram_model.sv
// behavioural ddr2/mddr sdram that answers the command sequencer pins
`timescale 1ns/1ps
// ==========================================================
// sdram partner
module dmcs_sdram_model (
  input wire logic clk, // memory clock
  input wire logic cke, // clock enable
  input wire logic cs_n, // chip select
  input wire logic ras_n, // row strobe
  input wire logic cas_n, // column strobe
  input wire logic we_n, // write enable
  input wire logic [2:0] ba, // bank select
  input wire logic [13:0] a, // address
  input wire logic [1:0] dqm, // write byte masks
  input wire logic [15:0] dq_o, // data from controller
  input wire logic dq_oe, // controller drives data
  input wire logic [2:0] cl, // cas latency
  input wire logic mddr, // mobile ddr write latency
  input wire logic [3:0] trcd, // activate to column
  input wire logic init_done, // mode writes must be over
  output logic [15:0] dq_i, // data to controller
  output int n_ref, // refreshes seen
  output int n_act, // activations seen
  output int viol // protocol faults seen
);
  logic [15:0] mem [256];
  logic [7:0] rs_b [32];
  logic [7:0] ws_b [32];
  logic [31:0] rs_v = 32'h0;
  logic [31:0] ws_v = 32'h0;
  logic [7:0] open_b = 8'h0;
  logic [7:0] rbase = 8'h0;
  logic [7:0] wbase = 8'h0;
  logic [7:0] idx;
  logic [2:0] cmd;
  int cyc = 0;
  int rbeat = 8;
  int wbeat = 8;
  int wl;
  int act_at [8];
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 16'(i) ^ 16'h5a00;
    dq_i = 16'h0;
    n_ref = 0;
    n_act = 0;
    viol = 0;
  end
  // data slots are keyed by cycle so a cut burst simply restarts the beat count
  always @(posedge clk) begin
    cmd = {ras_n, cas_n, we_n};
    idx = {ba, a[4:0]};
    wl = mddr ? 1 : int'(cl) - 1;
    if (cke && !cs_n) begin
      case (cmd)
        dmcs_pkg::CMD_ACT: begin
          open_b[ba] = 1'b1;
          act_at[ba] = cyc;
          n_act++;
        end
        dmcs_pkg::CMD_PRE: open_b = a[10] ? 8'h0 : open_b & ~(8'h01 << ba);
        dmcs_pkg::CMD_REF: begin
          if (open_b != 8'h0) viol++;
          n_ref++;
        end
        dmcs_pkg::CMD_MRS: begin
          // register picked by bank select; burst eight, cas latency, no additive latency
          if (open_b != 8'h0 || init_done || ba > dmcs_pkg::BA_EMR) viol++;
          if (ba == dmcs_pkg::BA_MR && (a[dmcs_pkg::MR_BL_LSB +: 3] != dmcs_pkg::MR_BL8
              || a[dmcs_pkg::MR_CL_LSB +: 3] != cl)) viol++;
          if (ba == dmcs_pkg::BA_EMR && a[dmcs_pkg::EMR_AL_LSB +: 3] != 3'h0) viol++;
        end
        dmcs_pkg::CMD_RD, dmcs_pkg::CMD_WR: begin
          if (!open_b[ba] || cyc - act_at[ba] < int'(trcd)) viol++;
          if (cmd == dmcs_pkg::CMD_RD) begin
            rs_v[(cyc + int'(cl) - 1) % 32] = 1'b1;
            rs_b[(cyc + int'(cl) - 1) % 32] = idx;
          end else begin
            ws_v[(cyc + wl) % 32] = 1'b1;
            ws_b[(cyc + wl) % 32] = idx;
          end
        end
        default: ;
      endcase
    end
    if (rs_v[cyc % 32]) begin
      rs_v[cyc % 32] = 1'b0;
      rbase = rs_b[cyc % 32];
      rbeat = 0;
    end
    if (rbeat < 8) begin
      dq_i <= mem[rbase + 8'(rbeat)];
      rbeat++;
    end else begin
      dq_i <= ~dq_i; // released bus keeps changing so stale data cannot pass
    end
    if (ws_v[cyc % 32]) begin
      ws_v[cyc % 32] = 1'b0;
      wbase = ws_b[cyc % 32];
      wbeat = 0;
    end
    if (dq_oe && wbeat < 8) begin
      if (!dqm[0]) mem[wbase + 8'(wbeat)][7:0] = dq_o[7:0];
      if (!dqm[1]) mem[wbase + 8'(wbeat)][15:8] = dq_o[15:8];
      wbeat++;
    end
    cyc++;
  end
endmodule

// File: test/dmcs_core_tb.sv
// self-checking bench for the ddr2/mddr command sequencer
`timescale 1ns/1ps
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin err_total++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module dmcs_core_tb;
  typedef struct packed {
    logic [2:0] cl;
    logic md;
    logic [2:0] bk;
    logic [13:0] row;
    logic [10:0] col;
    logic [3:0] len;
    logic [15:0] wbe;
  } dmcs_tb_row_s;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [12:0] cfg_ri = 13'h0190;
  logic [2:0] cfg_cl = 3'h3;
  logic cfg_md = 1'b0;
  logic [3:0] cfg_trcd = 4'h3;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic [2:0] req_bank = 3'h0;
  logic [13:0] req_row = 14'h0;
  logic [10:0] req_col = 11'h0;
  logic [3:0] req_len = 4'h1;
  logic [127:0] req_wdata = 128'h0;
  logic [15:0] req_wbe = 16'hffff;
  logic req_ready, rd_valid, init_done, cke, cs_n, ras_n, cas_n, we_n, dq_oe;
  logic [15:0] rd_data, dq_o, dq_i, e;
  logic [2:0] ba;
  logic [13:0] a;
  logic [1:0] dqm;
  int n_ref, n_act, viol;
  int err_total = 0;
  int compares = 0;
  int cycles = 0;
  logic [15:0] sh [256];
  logic [15:0] exp_q [$];
  dmcs_tb_row_s rows [6];
  dmcs_core #(.INIT_WAIT_CYC(20)) i_dmcs_core (
    .CLK_SYS(clk), .RST(rst), .CFG_REFRESH_INTERVAL(cfg_ri), .CFG_CAS_LAT(cfg_cl),
    .CFG_MDDR(cfg_md), .CFG_TRCD(cfg_trcd), .CFG_TRP(4'h2), .CFG_TRFC(8'h08),
    .CFG_EMR(14'h0), .REQ_VALID(req_valid), .REQ_READY(req_ready), .REQ_WRITE(req_write),
    .REQ_BANK(req_bank), .REQ_ROW(req_row), .REQ_COL(req_col), .REQ_LEN(req_len),
    .REQ_WDATA(req_wdata), .REQ_WBE(req_wbe), .RD_DATA(rd_data), .RD_VALID(rd_valid),
    .INIT_DONE(init_done), .DDR_CKE(cke), .DDR_CS_N(cs_n), .DDR_RAS_N(ras_n),
    .DDR_CAS_N(cas_n), .DDR_WE_N(we_n), .DDR_BA(ba), .DDR_A(a), .DDR_DQM(dqm),
    .DDR_DQ_O(dq_o), .DDR_DQ_OE(dq_oe), .DDR_DQ_I(dq_i));
  dmcs_sdram_model i_dmcs_sdram_model (
    .clk(clk), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
    .ba(ba), .a(a), .dqm(dqm), .dq_o(dq_o), .dq_oe(dq_oe), .cl(cfg_cl), .mddr(cfg_md),
    .trcd(cfg_trcd), .init_done(init_done), .dq_i(dq_i), .n_ref(n_ref), .n_act(n_act),
    .viol(viol));
  always #5 clk = ~clk;
  // ==========================================================
  // watchdog and read beat checker
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      results();
    end
  end
  always @(posedge clk) begin
    if (rd_valid === 1'b1) begin
      `CHK(exp_q.size() > 0, 1'b1)
      if (exp_q.size() > 0) begin
        e = exp_q.pop_front();
        `CHK(rd_data, e)
      end
    end
  end
  // ==========================================================
  // tasks, entered one delay after a rising edge, except results, which the watchdog calls on the edge itself
  task automatic results();
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic wait_init();
    int w;
    w = 0;
    while (init_done !== 1'b1 && w < 500) begin @(posedge clk); #1; w++; end
    `CHK(init_done, 1'b1)
    $display("init done");
  endtask
  task automatic xfer(input logic wr, input dmcs_tb_row_s r, input logic [15:0] seed);
    int w;
    logic [7:0] ix;
    ix = {r.bk, r.col[4:0]};
    req_valid = 1'b1;
    req_write = wr;
    req_bank = r.bk;
    req_row = r.row;
    req_col = r.col;
    req_len = r.len;
    req_wbe = r.wbe;
    for (int n = 0; n < 8; n++) begin
      req_wdata[16 * n +: 16] = seed + 16'(n * 16'h0111);
      if (wr && n < int'(r.len)) begin
        if (r.wbe[2 * n]) sh[ix + 8'(n)][7:0] = req_wdata[16 * n +: 8];
        if (r.wbe[2 * n + 1]) sh[ix + 8'(n)][15:8] = req_wdata[16 * n + 8 +: 8];
      end else if (!wr && n < int'(r.len)) exp_q.push_back(sh[ix + 8'(n)]);
    end
    w = 0;
    while (req_ready !== 1'b1 && w < 2000) begin @(posedge clk); #1; w++; end
    @(posedge clk);
    #1;
    req_valid = 1'b0;
    // let the write burst land before any read of the same place
    if (wr) #160;
  endtask
  task automatic drain();
    int w;
    w = 0;
    while (exp_q.size() != 0 && w < 300) begin @(posedge clk); #1; w++; end
    `CHK(exp_q.size(), 0)
  endtask
  // ==========================================================
  // main sequence
  initial begin
    dmcs_tb_row_s r;
    int r0;
    int w;
    for (int i = 0; i < 256; i++) sh[i] = 16'(i) ^ 16'h5a00;
    rows[0] = '{3'h3, 1'b0, 3'h0, 14'h0005, 11'h000, 4'h8, 16'hffff};
    rows[1] = '{3'h2, 1'b0, 3'h0, 14'h0005, 11'h008, 4'h3, 16'hffff};
    rows[2] = '{3'h4, 1'b1, 3'h3, 14'h0009, 11'h010, 4'h1, 16'h0002};
    rows[3] = '{3'h5, 1'b0, 3'h0, 14'h0007, 11'h000, 4'h8, 16'h5a3c};
    rows[4] = '{3'h5, 1'b1, 3'h7, 14'h3fff, 11'h418, 4'h5, 16'hfff3};
    rows[5] = '{3'h2, 1'b1, 3'h7, 14'h3fff, 11'h018, 4'h8, 16'hffff};
    repeat (3) @(posedge clk);
    #1;
    rst = 1'b0;
    wait_init();
    for (int k = 0; k < 6; k++) begin
      r = rows[k];
      cfg_cl = r.cl;
      cfg_md = r.md;
      xfer(1'b1, r, 16'(k) * 16'h1111);
      r.len = 4'h8;
      xfer(1'b0, r, 16'h0);
      drain();
      $display("row %0d done", k);
    end
    r0 = n_act;
    xfer(1'b0, r, 16'h0);
    drain();
    `CHK(n_act - r0, 0)
    r0 = n_ref;
    w = 0;
    while (n_ref == r0 && w < 1000) begin @(posedge clk); #1; w++; end
    r0 = n_act;
    xfer(1'b0, r, 16'h0);
    drain();
    `CHK(n_act - r0, 1)
    $display("page test done");
    r0 = n_ref;
    repeat (2000) @(posedge clk);
    #1;
    w = 2000 / int'(cfg_ri);
    `CHK((n_ref - r0 >= w - 1) && (n_ref - r0 <= w + 1), 1'b1)
    $display("refresh rate test done");
    r.len = 4'h2;
    xfer(1'b0, r, 16'h0);
    // one edge between requests so valid is never lowered and raised in one step
    @(posedge clk);
    #1;
    r.col = 11'h010;
    r.len = 4'h3;
    xfer(1'b0, r, 16'h0);
    drain();
    $display("back-to-back read test done");
    rst = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    `CHK({cke, cs_n, req_ready, init_done, dq_oe}, 5'h08)
    rst = 1'b0;
    wait_init();
    xfer(1'b0, rows[0], 16'h0);
    drain();
    `CHK(viol, 0)
    $display("reset test done");
    results();
  end
endmodule
